/* File: rtl/rc_pkg.sv */
package rc_pkg;
  // Time base and link timing.
  localparam int CLK_HZ    = 250_000_000;
  localparam int US_CYC    = CLK_HZ / 1_000_000;
  localparam int MS_US     = 1000;
  localparam int HOLD_S    = 10;
  localparam int HOLD_MS   = HOLD_S * 1000;
  localparam int LOSS_MS   = 250;
  localparam int CHAR_MS   = 8;
  localparam int STRING_MS = 200;
  localparam int SLOTS     = STRING_MS / CHAR_MS;
  localparam int BAUD      = 9600;
  localparam int BIT_CYC   = CLK_HZ / BAUD;
  localparam int FRAME_N   = 10;
  localparam int NVALS     = 12;
  localparam int CONF_N    = 12;
  localparam int CAL_IDX   = 9;
  // Pulse widths in microseconds.
  localparam logic [11:0] PW_LO  = 12'h320;
  localparam logic [11:0] PW_HI  = 12'h898;
  localparam logic [11:0] MIN_TR = 12'h0c8;
  localparam logic [11:0] FAC_MN = 12'h3e8;
  localparam logic [11:0] FAC_CT = 12'h5dc;
  localparam logic [11:0] FAC_MX = 12'h7d0;
  // Command scale and accessory thresholds.
  localparam logic signed [7:0] CMD_FULL = 8'sh7f;
  localparam logic signed [7:0] ACC_ON   = 8'sh60;
  localparam logic signed [7:0] ACC_CTR  = 8'sh20;
  localparam logic signed [4:0] TUNE_MAX = 5'sh0a;
  localparam int TRIM_MUL = 41;
  localparam int TRIM_SH  = 12;
  // Characters.
  localparam logic [7:0] CH_ZERO  = 8'h30;
  localparam logic [7:0] CH_ALPHA = 8'h37;
  localparam logic [7:0] CH_MINUS = 8'h2d;
  localparam logic [7:0] CH_O     = 8'h6f;
  localparam logic [7:0] CH_CR    = 8'h0d;
  // Register offsets.
  localparam logic [3:0] ADDR_TUNE = 4'h0;
  localparam logic [3:0] ADDR_STAT = 4'h4;
  localparam logic [3:0] ADDR_CMD  = 4'h8;

  typedef struct packed {
    logic [11:0] mn;
    logic [11:0] ct;
    logic [11:0] mx;
  } cal_type;
  typedef cal_type [1:0] cal_pair_type;
  typedef struct packed {
    logic [7:0] power;
    logic [7:0] ana1;
    logic [7:0] ana2;
    logic [7:0] amp1;
    logic [7:0] amp2;
    logic [7:0] tmp1;
    logic [7:0] tmp2;
    logic [7:0] batt;
    logic [7:0] v12;
    logic [7:0] enc;
  } telem_type;
  typedef enum logic [2:0] {
    M_RUN  = 3'b000,
    M_HOLD = 3'b001,
    M_CONF = 3'b010,
    M_CAL  = 3'b011
  } mode_type;
  typedef enum logic [1:0] {
    Z_CTR = 2'b00,
    Z_MAX = 2'b01,
    Z_MIN = 2'b10
  } zone_type;
  localparam cal_type FACTORY = '{mn: FAC_MN, ct: FAC_CT, mx: FAC_MX};
endpackage : rc_pkg

/* File: rtl/rc_joystick_calib_accessory.sv */
// Function
// - Button held ten seconds enters configuration
// - Program steps parameter, set starts calibration
// - Track extremes, program stores center too
// - No pulses means stored values stay
// - Only channels that pulsed get updated
// - Widen spans shorter than minimum travel
// - Channel three uses fixed factory timing
// - Accessories follow channel three only
// - Follow output on at max, off center
// - Toggle output flips on center to min
// - Radio mode sends twelve hex pairs
// - Fixed order of twelve logged values
// - Whole string repeats every 200 ms
// - Trim gives one side up to 10%
// - Width maps to command -127..+127
// - Radio loss switches both accessories off
// - One logging character every 8 ms
// - 9600 baud, 7 data, even parity
//
// The placing of the registers and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module rc_joystick_calib_accessory #(
  parameter int US_CYC  = rc_pkg::US_CYC,
  parameter int HOLD_MS = rc_pkg::HOLD_MS,
  parameter int BIT_CYC = rc_pkg::BIT_CYC,
  parameter int CONF_N  = rc_pkg::CONF_N,
  parameter int CAL_IDX = rc_pkg::CAL_IDX
) (
  // Clock and reset.
  input  wire logic                 ref_clk_in,
  input  wire logic                 rst_in,
  // Radio pulses and buttons.
  input  wire logic [2:0]           rc_pulse_in,
  input  wire logic                 prog_btn_in,
  input  wire logic                 set_btn_in,
  // Non-volatile calibration store.
  input  wire rc_pkg::cal_pair_type nvm_cal_in,
  output logic                      nvm_wr_out,
  output rc_pkg::cal_pair_type      nvm_cal_out,
  // Values to log.
  input  wire rc_pkg::telem_type    telem_in,
  input  wire logic                 enc_present_in,
  // Register port.
  input  wire logic [3:0]           reg_addr_in,
  input  wire logic [31:0]          reg_wdata_in,
  input  wire logic                 reg_wr_in,
  input  wire logic                 reg_rd_in,
  output logic [31:0]               reg_rdata_out,
  // Outputs.
  output logic                      acc_follow_out,
  output logic                      acc_toggle_out,
  output logic signed [7:0]         drive1_out,
  output logic signed [7:0]         drive2_out,
  output logic                      radio_ok_out,
  output rc_pkg::mode_type          mode_out,
  output logic [3:0]                disp_param_out,
  output logic [7:0]                disp_char_out,
  output logic                      tx_out
);

  // Width to signed command against min, center and max.
  function automatic logic signed [7:0] conv(input logic [11:0] w,
                                             input rc_pkg::cal_type c);
    logic [11:0] d;
    logic [11:0] s;
    logic [18:0] q;
    if (w >= c.ct) begin
      d = w - c.ct;
      s = c.mx - c.ct;
    end else begin
      d = c.ct - w;
      s = c.ct - c.mn;
    end
    q = (s == 12'h0) ? 19'h7f : (19'(d) * 19'd127) / 19'(s);
    if (q > 19'h7f) q = 19'h7f;
    conv = (w >= c.ct) ? $signed(q[7:0]) : -$signed(q[7:0]);
  endfunction : conv

  // Learned span with a forced least travel either side.
  function automatic rc_pkg::cal_type widen(input logic [11:0] lo,
                                            input logic [11:0] hi,
                                            input logic [11:0] ct);
    widen.ct = ct;
    widen.mn = (lo + rc_pkg::MIN_TR > ct) ? ct - rc_pkg::MIN_TR : lo;
    widen.mx = (hi < ct + rc_pkg::MIN_TR) ? ct + rc_pkg::MIN_TR : hi;
  endfunction : widen

  // Command scaled by 100+p percent, clamped to full scale.
  function automatic logic signed [7:0] trim(input logic signed [7:0] c,
                                             input logic [3:0] p);
    logic signed [23:0] t;
    t = (24'(c) * $signed(24'(100 + int'(p))) * 24'(rc_pkg::TRIM_MUL))
        >>> rc_pkg::TRIM_SH;
    if (t > 24'sd127) trim = rc_pkg::CMD_FULL;
    else if (t < -24'sd127) trim = -rc_pkg::CMD_FULL;
    else trim = 8'(t);
  endfunction : trim

  // Uppercase hex digit.
  function automatic logic [7:0] hex(input logic [3:0] n);
    hex = (n < 4'ha) ? rc_pkg::CH_ZERO + 8'(n) : rc_pkg::CH_ALPHA + 8'(n);
  endfunction : hex

  ////////////////////////////////////////////////////////////////////////////
  logic [4:0]            pin_w;
  logic [4:0]            lvl_w;
  logic [4:0]            lvl_d_r;
  logic [4:0]            press_w;
  logic [11:0]           width_w [3];
  logic [2:0]            pv_w;
  logic signed [7:0]     cmd_w [3];
  logic [2:0]            cv_w;
  rc_pkg::cal_type [1:0] cal_r;
  rc_pkg::cal_type [2:0] cal_all_w;
  logic [7:0]            us_cnt_r;
  logic                  us_tick_r;
  logic [9:0]            ms_cnt_r;
  logic                  ms_tick_r;

  assign pin_w     = {set_btn_in, prog_btn_in, rc_pulse_in};
  assign press_w   = lvl_w & ~lvl_d_r;
  assign cal_all_w = {rc_pkg::FACTORY, cal_r};

  // Microsecond and millisecond ticks.
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      us_cnt_r  <= 8'h0;
      us_tick_r <= 1'b0;
      ms_cnt_r  <= 10'h0;
      ms_tick_r <= 1'b0;
    end else begin
      us_tick_r <= (us_cnt_r == 8'(US_CYC - 1));
      us_cnt_r  <= (us_cnt_r == 8'(US_CYC - 1)) ? 8'h0 : us_cnt_r + 8'h1;
      ms_tick_r <= us_tick_r && (ms_cnt_r == 10'(rc_pkg::MS_US - 1));
      if (us_tick_r) begin
        ms_cnt_r <= (ms_cnt_r == 10'(rc_pkg::MS_US - 1)) ? 10'h0 : ms_cnt_r + 10'h1;
      end
    end
  end

  // Button edge memory.
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) lvl_d_r <= 5'h0;
    else lvl_d_r <= lvl_w;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: a level counts once stages two and three agree.
  for (genvar g = 0; g < 5; g++) begin : g_sync
    logic [2:0] sh_r;
    logic       lvl_r;
    always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
        sh_r  <= 3'h0;
        lvl_r <= 1'b0;
      end else begin
        sh_r <= {sh_r[1:0], pin_w[g]};
        if (sh_r[1] == sh_r[2]) lvl_r <= sh_r[2];
      end
    end
    assign lvl_w[g] = lvl_r;
  end

  // Pulse width capture and conversion per radio channel.
  for (genvar g = 0; g < 3; g++) begin : g_chan
    logic              hi_d_r;
    logic [11:0]       cnt_r;
    logic [11:0]       w_r;
    logic              pv_r;
    logic signed [7:0] cmd_r;
    logic              cv_r;
    always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
        hi_d_r <= 1'b0;
        cnt_r  <= 12'h0;
        w_r    <= rc_pkg::FAC_CT;
        pv_r   <= 1'b0;
      end else begin
        hi_d_r <= lvl_w[g];
        if (lvl_w[g] && !hi_d_r) cnt_r <= {11'h0, us_tick_r};
        else if (lvl_w[g] && us_tick_r && cnt_r != 12'hfff) cnt_r <= cnt_r + 12'h1;
        pv_r <= !lvl_w[g] && hi_d_r && cnt_r >= rc_pkg::PW_LO && cnt_r <= rc_pkg::PW_HI;
        if (!lvl_w[g] && hi_d_r && cnt_r >= rc_pkg::PW_LO && cnt_r <= rc_pkg::PW_HI) begin
          w_r <= cnt_r;
        end
      end
    end
    // Command follows each accepted pulse by one cycle.
    always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
        cmd_r <= 8'sh0;
        cv_r  <= 1'b0;
      end else begin
        cv_r <= pv_r;
        if (pv_r) cmd_r <= conv(w_r, cal_all_w[g]);
      end
    end
    assign width_w[g] = w_r;
    assign pv_w[g]    = pv_r;
    assign cmd_w[g]   = cmd_r;
    assign cv_w[g]    = cv_r;
  end

  ////////////////////////////////////////////////////////////////////////////
  rc_pkg::mode_type mode_r;
  logic [13:0]      hold_cnt_r;
  logic [3:0]       param_r;
  logic [1:0]       seen_r;
  logic [11:0]      lo_r [2];
  logic [11:0]      hi_r [2];
  logic             store_w;
  logic             nvm_wr_r;

  assign store_w = (mode_r == rc_pkg::M_CAL) && press_w[3];

  // Mode sequence: hold check, configuration, calibration.
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      mode_r     <= rc_pkg::M_HOLD;
      hold_cnt_r <= 14'h0;
      param_r    <= 4'h0;
    end else begin
      case (mode_r)
        rc_pkg::M_HOLD: begin
          if (ms_tick_r) begin
            if (!lvl_w[3]) mode_r <= rc_pkg::M_RUN;
            else if (hold_cnt_r == 14'(HOLD_MS - 1)) mode_r <= rc_pkg::M_CONF;
            else hold_cnt_r <= hold_cnt_r + 14'h1;
          end
        end
        rc_pkg::M_CONF: begin
          if (press_w[3]) begin
            param_r <= (param_r == 4'(CONF_N - 1)) ? 4'h0 : param_r + 4'h1;
          end else if (press_w[4] && param_r == 4'(CAL_IDX)) begin
            mode_r <= rc_pkg::M_CAL;
          end
        end
        rc_pkg::M_CAL: begin
          if (press_w[3]) mode_r <= rc_pkg::M_CONF;
        end
        rc_pkg::M_RUN: mode_r <= rc_pkg::M_RUN;
        default: mode_r <= rc_pkg::M_RUN;
      endcase
    end
  end

  // Extreme tracking while calibrating, restarted on entry.
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      seen_r <= 2'b00;
      for (int i = 0; i < 2; i++) begin
        lo_r[i] <= 12'hfff;
        hi_r[i] <= 12'h0;
      end
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (mode_r == rc_pkg::M_CONF) begin
          seen_r[i] <= 1'b0;
          lo_r[i]   <= 12'hfff;
          hi_r[i]   <= 12'h0;
        end else if (mode_r == rc_pkg::M_CAL && pv_w[i]) begin
          seen_r[i] <= 1'b1;
          if (width_w[i] < lo_r[i]) lo_r[i] <= width_w[i];
          if (width_w[i] > hi_r[i]) hi_r[i] <= width_w[i];
        end
      end
    end
  end

  // Calibration store: load at reset, write back on program press.
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      cal_r    <= nvm_cal_in;
      nvm_wr_r <= 1'b0;
    end else begin
      nvm_wr_r <= store_w && (|seen_r);
      for (int i = 0; i < 2; i++) begin
        if (store_w && seen_r[i]) begin
          cal_r[i] <= widen(lo_r[i], hi_r[i], width_w[i]);
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  logic [8:0]       gap_r;
  logic             radio_ok_r;
  rc_pkg::zone_type zone_r;
  rc_pkg::zone_type nz;
  logic             follow_r;
  logic             toggle_r;

  // Radio loss watchdog over all channels.
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      gap_r      <= 9'h0;
      radio_ok_r <= 1'b0;
    end else if (|pv_w) begin
      gap_r      <= 9'h0;
      radio_ok_r <= 1'b1;
    end else if (ms_tick_r && radio_ok_r) begin
      gap_r <= gap_r + 9'h1;
      if (gap_r == 9'(rc_pkg::LOSS_MS - 1)) radio_ok_r <= 1'b0;
    end
  end

  // Channel three zone with separate enter and leave thresholds.
  always_comb begin
    nz = zone_r;
    if (cmd_w[2] >= rc_pkg::ACC_ON) nz = rc_pkg::Z_MAX;
    else if (cmd_w[2] <= -rc_pkg::ACC_ON) nz = rc_pkg::Z_MIN;
    else if (cmd_w[2] <= rc_pkg::ACC_CTR && cmd_w[2] >= -rc_pkg::ACC_CTR) nz = rc_pkg::Z_CTR;
  end

  // Accessory outputs driven from channel three alone.
  always_ff @(posedge ref_clk_in) begin
    if (rst_in || !radio_ok_r) begin
      zone_r   <= rc_pkg::Z_CTR;
      follow_r <= 1'b0;
      toggle_r <= 1'b0;
    end else if (cv_w[2]) begin
      zone_r <= nz;
      if (nz == rc_pkg::Z_MAX) follow_r <= 1'b1;
      else if (nz == rc_pkg::Z_CTR) follow_r <= 1'b0;
      if (zone_r == rc_pkg::Z_CTR && nz == rc_pkg::Z_MIN) toggle_r <= ~toggle_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  logic signed [4:0] tune_r;
  logic signed [4:0] tw;
  logic [31:0]       rdata_r;
  logic signed [7:0] d1_r;
  logic signed [7:0] d2_r;

  assign tw = $signed(reg_wdata_in[4:0]);

  // Register writes: trim clamped to the allowed range.
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) tune_r <= 5'sh0;
    else if (reg_wr_in && reg_addr_in == rc_pkg::ADDR_TUNE) begin
      if (tw > rc_pkg::TUNE_MAX) tune_r <= rc_pkg::TUNE_MAX;
      else if (tw < -rc_pkg::TUNE_MAX) tune_r <= -rc_pkg::TUNE_MAX;
      else tune_r <= tw;
    end
  end

  // Register reads answer in the next cycle only.
  always_ff @(posedge ref_clk_in) begin
    if (rst_in || !reg_rd_in) rdata_r <= 32'h0;
    else begin
      case (reg_addr_in)
        rc_pkg::ADDR_TUNE: rdata_r <= {{27{tune_r[4]}}, tune_r};
        rc_pkg::ADDR_STAT: rdata_r <= {20'h0, param_r, seen_r, toggle_r, follow_r,
                                       radio_ok_r, mode_r};
        rc_pkg::ADDR_CMD:  rdata_r <= {8'h0, cmd_w[2], cmd_w[1], cmd_w[0]};
        default:           rdata_r <= 32'h0;
      endcase
    end
  end

  // Per-channel drive with left/right trim.
  always_ff @(posedge ref_clk_in) begin
    if (rst_in || mode_r != rc_pkg::M_RUN || !radio_ok_r) begin
      d1_r <= 8'sh0;
      d2_r <= 8'sh0;
    end else begin
      d1_r <= trim(cmd_w[0], tune_r[4] ? 4'h0 : tune_r[3:0]);
      d2_r <= trim(cmd_w[1], tune_r[4] ? 4'(-tune_r) : 4'h0);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  logic [2:0]  sub_r;
  logic [4:0]  slot_r;
  logic        kick_r;
  logic [7:0]  ch_r;
  logic [7:0]  snap_r [rc_pkg::NVALS];
  logic [7:0]  vals_w [rc_pkg::NVALS];
  logic [9:0]  frame_r;
  logic [3:0]  left_r;
  logic [14:0] tm_r;
  logic [7:0]  sel_w;

  // Logged values in their fixed order.
  always_comb begin
    vals_w[0]  = cmd_w[0];
    vals_w[1]  = cmd_w[1];
    vals_w[2]  = telem_in.power;
    vals_w[3]  = telem_in.ana1;
    vals_w[4]  = telem_in.ana2;
    vals_w[5]  = telem_in.amp1;
    vals_w[6]  = telem_in.amp2;
    vals_w[7]  = telem_in.tmp1;
    vals_w[8]  = telem_in.tmp2;
    vals_w[9]  = telem_in.batt;
    vals_w[10] = telem_in.v12;
    vals_w[11] = enc_present_in ? telem_in.enc : 8'h0;
  end

  assign sel_w = snap_r[slot_r[4:1]];

  // Character slots of 8 ms, string of 25 slots.
  always_ff @(posedge ref_clk_in) begin
    if (rst_in || mode_r != rc_pkg::M_RUN) begin
      sub_r  <= 3'h0;
      slot_r <= 5'h0;
      kick_r <= 1'b0;
      ch_r   <= rc_pkg::CH_CR;
      for (int i = 0; i < rc_pkg::NVALS; i++) snap_r[i] <= 8'h0;
    end else begin
      kick_r <= 1'b0;
      if (ms_tick_r) sub_r <= (sub_r == 3'(rc_pkg::CHAR_MS - 1)) ? 3'h0 : sub_r + 3'h1;
      if (ms_tick_r && sub_r == 3'(rc_pkg::CHAR_MS - 1)) begin
        kick_r <= 1'b1;
        if (slot_r < 5'(2 * rc_pkg::NVALS)) begin
          ch_r <= hex(slot_r[0] ? sel_w[3:0] : sel_w[7:4]);
        end else ch_r <= rc_pkg::CH_CR;
        if (slot_r == 5'(rc_pkg::SLOTS - 1)) begin
          slot_r <= 5'h0;
          for (int i = 0; i < rc_pkg::NVALS; i++) snap_r[i] <= vals_w[i];
        end else slot_r <= slot_r + 5'h1;
      end
    end
  end

  // Serial frame: start, 7 data LSB first, even parity, stop.
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      frame_r <= 10'h3ff;
      left_r  <= 4'h0;
      tm_r    <= 15'h0;
    end else if (kick_r && left_r == 4'h0) begin
      frame_r <= {1'b1, ^ch_r[6:0], ch_r[6:0], 1'b0};
      left_r  <= 4'(rc_pkg::FRAME_N);
      tm_r    <= 15'h0;
    end else if (left_r != 4'h0) begin
      if (tm_r == 15'(BIT_CYC - 1)) begin
        tm_r    <= 15'h0;
        frame_r <= {1'b1, frame_r[9:1]};
        left_r  <= left_r - 4'h1;
      end else tm_r <= tm_r + 15'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output drive.
  assign nvm_wr_out     = nvm_wr_r;
  assign nvm_cal_out    = cal_r;
  assign reg_rdata_out  = rdata_r;
  assign acc_follow_out = follow_r;
  assign acc_toggle_out = toggle_r;
  assign drive1_out     = d1_r;
  assign drive2_out     = d2_r;
  assign radio_ok_out   = radio_ok_r;
  assign mode_out       = mode_r;
  assign disp_param_out = param_r;
  assign tx_out         = frame_r[0];

  // Display character for the shown parameter.
  always_comb begin
    if (mode_r == rc_pkg::M_CAL) disp_char_out = rc_pkg::CH_O;
    else if (mode_r == rc_pkg::M_CONF && param_r == 4'(CAL_IDX)) disp_char_out = rc_pkg::CH_MINUS;
    else disp_char_out = rc_pkg::CH_ZERO;
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);

  sequence s_store;
    mode_r == rc_pkg::M_CAL && press_w[3];
  endsequence

  chk_hold_enter: assert property (
    mode_r == rc_pkg::M_CONF && $past(mode_r) == rc_pkg::M_HOLD
    |-> $past(hold_cnt_r) == 14'(HOLD_MS - 1))
    else $error("configuration entered before hold time");
  chk_store_write: assert property (
    s_store ##0 (|seen_r) |=> nvm_wr_r ##1 !nvm_wr_r)
    else $error("calibration store not written once");
  chk_store_none: assert property (
    s_store ##0 seen_r == 2'b00 |=> !nvm_wr_r && $stable(cal_r))
    else $error("calibration changed without pulses");
  chk_store_one: assert property (
    s_store ##0 seen_r == 2'b01
    |=> cal_r[1] == $past(cal_r[1]) && cal_r[0].ct == $past(width_w[0]))
    else $error("wrong channel calibrated");
  chk_min_travel: assert property (
    nvm_wr_r && seen_r[0] |-> cal_r[0].mx >= cal_r[0].ct + rc_pkg::MIN_TR
    && cal_r[0].mn + rc_pkg::MIN_TR <= cal_r[0].ct)
    else $error("span below minimum travel");
  chk_follow_max: assert property (
    cv_w[2] && radio_ok_r && nz == rc_pkg::Z_MAX |=> follow_r)
    else $error("follow output not set at max");
  chk_toggle_flip: assert property (
    cv_w[2] && radio_ok_r && zone_r == rc_pkg::Z_CTR && nz == rc_pkg::Z_MIN
    |=> toggle_r != $past(toggle_r))
    else $error("toggle output did not flip");
  chk_cmd_range: assert property (
    cv_w[0] |-> cmd_w[0] >= -rc_pkg::CMD_FULL)
    else $error("command below -127");
  chk_lost_off: assert property (
    !radio_ok_r |=> !follow_r && !toggle_r)
    else $error("accessory on after radio loss");
  chk_tx_quiet: assert property (
    mode_r != rc_pkg::M_RUN && left_r == 4'h0 |-> tx_out)
    else $error("serial line active outside radio mode");
endmodule : rc_joystick_calib_accessory
`default_nettype wire

/* File: dv/rc_radio_term.sv */
`timescale 1ns/1ps
`default_nettype none
module rc_radio_term #(
  parameter int US_CYC  = 1,
  parameter int BIT_CYC = 8
) (
  // Clock.
  input  wire logic       ref_clk_in,
  // Receiver pulses, terminal line and what the terminal heard.
  output logic [2:0]      pulse_out,
  input  wire logic       tx_in,
  output logic [7:0]      rx_first_out,
  output logic            rx_par_ok_out,
  output var int          rx_count_out
);
  ////////////////////////////////////////////////////////////////////////////
  // Receiver side: pulse lines idle low between pulses.
  initial pulse_out = 3'h0;

  // Sends one pulse of the given width in microseconds, then a short gap.
  task automatic pulse(input int ch, input int us);
    @(posedge ref_clk_in);
    pulse_out[ch] <= 1'b1;
    repeat (us * US_CYC) @(posedge ref_clk_in);
    pulse_out[ch] <= 1'b0;
    repeat (2500) @(posedge ref_clk_in);
  endtask : pulse

  ////////////////////////////////////////////////////////////////////////////
  // Terminal: samples mid-bit, seven data bits LSB first, parity, stop.
  initial begin
    logic [8:0] f;
    rx_count_out  = 0;
    rx_first_out  = 8'h00;
    rx_par_ok_out = 1'b0;
    forever begin
      @(negedge tx_in);
      repeat (BIT_CYC / 2) @(posedge ref_clk_in);
      for (int i = 0; i < 9; i++) begin
        repeat (BIT_CYC) @(posedge ref_clk_in);
        f[i] = tx_in;
      end
      if (rx_count_out == 0) begin
        rx_first_out  = {1'b0, f[6:0]};
        rx_par_ok_out = (^f[7:0] == 1'b0) && f[8];
      end
      rx_count_out++;
    end
  end
endmodule : rc_radio_term
`default_nettype wire

/* File: dv/rc_joystick_calib_accessory_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module rc_joystick_calib_accessory_tb;
  localparam int BITC = 8;
  logic               ref_clk_in;
  logic               rst_in;
  logic               enc_present_in;
  rc_pkg::telem_type  telem_in;
  logic [3:0]         reg_addr_in;
  logic [31:0]        reg_wdata_in;
  logic               reg_wr_in;
  logic               reg_rd_in;
  logic [31:0]        reg_rdata_out;
  logic [2:0]         pulse;
  logic [1:0]         btn = 2'b00;
  logic [7:0]         disp_char;
  logic               acc_follow_out;
  logic               acc_toggle_out;
  logic               radio_ok_out;
  logic               nvm_wr_out;
  logic               tx_out;
  logic signed [7:0]  drive1_out;
  rc_pkg::mode_type   mode_out;
  rc_pkg::cal_pair_type nvm_cal_out;
  logic [7:0]         rx_first;
  logic               rx_par_ok;
  int                 rx_count;
  int                 fail_count = 0;
  int                 n_compared = 0;

  rc_joystick_calib_accessory #(.HOLD_MS(2), .BIT_CYC(BITC), .US_CYC(1)) u_dut (
    .ref_clk_in(ref_clk_in), .rst_in(rst_in), .rc_pulse_in(pulse),
    .prog_btn_in(btn[0]), .set_btn_in(btn[1]),
    .nvm_cal_in({rc_pkg::FACTORY, rc_pkg::FACTORY}), .nvm_wr_out(nvm_wr_out),
    .nvm_cal_out(nvm_cal_out), .telem_in(telem_in), .enc_present_in(enc_present_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
    .acc_follow_out(acc_follow_out), .acc_toggle_out(acc_toggle_out),
    .drive1_out(drive1_out), .drive2_out(), .radio_ok_out(radio_ok_out),
    .mode_out(mode_out), .disp_param_out(), .disp_char_out(disp_char), .tx_out(tx_out));

  rc_radio_term #(.BIT_CYC(BITC)) u_peer (
    .ref_clk_in(ref_clk_in), .pulse_out(pulse), .tx_in(tx_out),
    .rx_first_out(rx_first), .rx_par_ok_out(rx_par_ok), .rx_count_out(rx_count));

  ////////////////////////////////////////////////////////////////////////////
  // Clock at 250 MHz.
  initial begin
    ref_clk_in = 1'b0;
    forever #2 ref_clk_in = ~ref_clk_in;
  end

  // Compares one value and counts the result.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  // One-cycle register write.
  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    reg_wr_in    <= 1'b1;
    @(posedge ref_clk_in);
    reg_wr_in <= 1'b0;
  endtask : reg_wr

  // One-cycle register read; data taken in the next cycle.
  task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
    reg_addr_in <= a;
    reg_rd_in   <= 1'b1;
    @(posedge ref_clk_in);
    reg_rd_in <= 1'b0;
    #1 d = reg_rdata_out;
    @(posedge ref_clk_in);
  endtask : reg_rd

  // Expected trim after clamping to the allowed span.
  function automatic logic [4:0] clamp5(input int v);
    return (v > 10) ? 5'h0a : (v < -10) ? 5'h16 : 5'(v);
  endfunction : clamp5

  // Channel 3 pulse, then accessories and command checked.
  task automatic acc(input int us, input logic f, input logic t, input logic [7:0] c);
    logic [31:0] d;
    u_peer.pulse(2, us);
    reg_rd(rc_pkg::ADDR_CMD, d);
    chk(d[23:16], c, "ch3 command");
    chk(acc_follow_out, f, "follow output");
    chk(acc_toggle_out, t, "toggle output");
  endtask : acc

  // Presses one button through the synchroniser.
  task automatic press(input int b);
    repeat (6) @(posedge ref_clk_in);
    btn[b] <= 1'b1;
    repeat (6) @(posedge ref_clk_in);
    btn[b] <= 1'b0;
  endtask : press

  // Ends the run with the verdict.
  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : close_out

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog at 100,000 cycles, about two and a half times the run.
  initial begin
    #400_000;
    fail_count++;
    close_out();
  end

  // Main sequence.
  initial begin
    logic [31:0] d;
    int          v;
    int          tv[3] = '{10, 11, -11};
    void'($urandom(65789));
    rst_in = 1'b1;
    enc_present_in = 1'b0;
    telem_in = '0;
    reg_addr_in = 4'h0;
    reg_wdata_in = 32'h0;
    reg_wr_in = 1'b0;
    reg_rd_in = 1'b0;
    repeat (3) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    telem_in <= 80'({$urandom, $urandom, $urandom});
    enc_present_in <= 1'($urandom);
    @(posedge ref_clk_in);
    #1 chk(mode_out, rc_pkg::M_HOLD, "mode after reset");
    chk(tx_out, 1'b1, "line idle");
    chk({acc_follow_out, acc_toggle_out, nvm_wr_out}, 3'h0, "outputs after reset");
    chk(nvm_cal_out[0].ct, rc_pkg::FAC_CT, "stored calibration kept");
    @(posedge ref_clk_in);
    // Trim corners and random values, then an unmapped read.
    for (int i = 0; i < 11; i++) begin
      v = (i < 3) ? tv[i] : int'($urandom_range(31)) - 16;
      reg_wr(rc_pkg::ADDR_TUNE, 32'(v));
      reg_rd(rc_pkg::ADDR_TUNE, d);
      chk(d[4:0], clamp5(v), "tune clamp");
    end
    reg_rd(4'hc, d);
    chk(d, 32'h0, "unmapped read");
    for (int i = 0; i < 5000 && mode_out !== rc_pkg::M_RUN; i++) @(posedge ref_clk_in);
    chk(mode_out, rc_pkg::M_RUN, "radio mode reached");
    // Max sets follow, mid travel holds it, center clears, min flips toggle.
    acc(2000, 1'b1, 1'b0, 8'h7f);
    chk(radio_ok_out, 1'b1, "radio seen");
    acc(1700, 1'b1, 1'b0, 8'h32);
    acc(1500, 1'b0, 1'b0, 8'h00);
    acc(1000, 1'b0, 1'b1, 8'h81);
    acc(1500, 1'b0, 1'b1, 8'h00);
    acc(1000, 1'b0, 1'b0, 8'h81);
    chk(drive1_out, 8'h00, "idle stick drive");
    for (int i = 0; i < 20000 && rx_count == 0; i++) @(posedge ref_clk_in);
    chk(rx_first, 8'h30, "first log char");
    chk(rx_par_ok, 1'b1, "frame parity and stop");
    // Reset with program held, then calibrate channel 1 alone.
    rst_in <= 1'b1;
    btn <= 2'b01;
    repeat (3) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    repeat (2100) @(posedge ref_clk_in);
    chk(mode_out, rc_pkg::M_CONF, "held button");
    btn <= 2'b00;
    repeat (9) press(0);
    chk(disp_char, rc_pkg::CH_MINUS, "prompt");
    press(1);
    chk(disp_char, rc_pkg::CH_O, "cal mode");
    for (int i = 0; i < 3; i++) u_peer.pulse(0, 1450 + 50 * i);
    press(0);
    chk(nvm_cal_out == {rc_pkg::FACTORY, 36'h54660e6d6}, 1'b1, "stored");
    press(1);
    press(0);
    chk(nvm_cal_out == {rc_pkg::FACTORY, 36'h54660e6d6}, 1'b1, "no pulses");
    close_out();
  end
endmodule : rc_joystick_calib_accessory_tb
`default_nettype wire
